/* File: verilog/laser_safety_pkg.sv */
package laser_safety_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PWR_LO = 8'h04;
  localparam logic [7:0] ADDR_PWR_HI = 8'h08;
  localparam logic [7:0] ADDR_FRAME = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_INT_STAT = 8'h14;
  localparam logic [7:0] ADDR_INT_MASK = 8'h18;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_BIT = 0;
  localparam int FAULT_CLEAR_BIT = 1;
  localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
  localparam logic [7:0] PWR_LO_RST = 8'h00;
  localparam logic [7:0] PWR_HI_RST = 8'h00;
  localparam logic [15:0] FRAME_LEN_RST = 16'h00C8;
  localparam logic [15:0] LIGHT_LEN_RST = 16'h0040;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  // ----------------------------------------------------------------
  // self-test timing
  // ----------------------------------------------------------------
  localparam int TEST_STEP_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] TEST_STEP_CYC = 8'((TEST_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {MODE_SHUTTER_E, MODE_CONT_E} mode_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_GND, ST_SUPPLY, ST_INJECT, ST_DONE
  } test_state_t;
endpackage

/* File: verilog/fault_if.sv */
`timescale 1ns/1ps
interface fault_if;
  logic rbinShort;
  logic driveShortGnd;
  logic driveShortSup;
  logic injectFault;
  modport sync (input injectFault, output rbinShort, driveShortGnd, driveShortSup);
  modport core (output injectFault, input rbinShort, driveShortGnd, driveShortSup);
endinterface

/* File: verilog/fault_sync.sv */
`timescale 1ns/1ps
module fault_sync (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rbinLowRaw,
  input wire logic driveLowRaw,
  input wire logic driveHighRaw,
  fault_if.sync flt
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] raw;
  // ----------------------------------------------------------------
  // two-stage synchronisers, one per comparator
  // ----------------------------------------------------------------
  assign raw = {driveHighRaw, driveLowRaw, rbinLowRaw};
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= raw[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  // injected test fault forces the ground detector, proving the path
  assign flt.rbinShort = sync_q[0];
  assign flt.driveShortGnd = sync_q[1] | flt.injectFault;
  assign flt.driveShortSup = sync_q[2];
endmodule

/* File: verilog/laser_drive_safety_control.sv */
// Function
// - continuous mode: drive on unless powered down
// - shutter mode: drive only in light window
// - one config bit selects the mode
// - watch bias and drive pins for shorts
// - fault cuts current source, enable high
// - supply enable low normally, high on fault
// - low power config write starts self-test
// - self-test checks gnd, supply, detector path
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module laser_drive_safety_control (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic power_down_n,
  input wire logic rbinLowRaw,
  input wire logic driveLowRaw,
  input wire logic driveHighRaw,
  output logic driveCurrentEn,
  output logic emitter_supply_enable_n,
  output logic [7:0] emitter_power_cfg_lo,
  output logic [7:0] emitter_power_cfg_hi,
  output logic irq
);
  fault_if flt();
  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic pdMeta_q;
  logic pdSync_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pdMeta_q <= 1'b0;
      pdSync_q <= 1'b0;
    end else begin
      pdMeta_q <= power_down_n;
      pdSync_q <= pdMeta_q;
    end
  end
  fault_sync u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .rbinLowRaw(rbinLowRaw),
    .driveLowRaw(driveLowRaw),
    .driveHighRaw(driveHighRaw),
    .flt(flt)
  );
  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic [7:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic accept;
  logic doWrite;
  logic doRead;
  assign accept = hsel & hready & htrans[1];
  assign doWrite = wr_q;
  assign doRead = rd_q;
  // address is held between transfers so hrdata stays steady while idle
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      addr_q <= 8'h00;
    end else if (accept) begin
      addr_q <= haddr[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= accept & hwrite;
      rd_q <= accept & ~hwrite;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  logic wrCfg;
  logic wrLo;
  logic wrHi;
  logic wrFrame;
  logic wrMask;
  logic rdStat;
  assign wrCfg = doWrite && addr_q == laser_safety_pkg::ADDR_CONFIG;
  assign wrLo = doWrite && addr_q == laser_safety_pkg::ADDR_PWR_LO;
  assign wrHi = doWrite && addr_q == laser_safety_pkg::ADDR_PWR_HI;
  assign wrFrame = doWrite && addr_q == laser_safety_pkg::ADDR_FRAME;
  assign wrMask = doWrite && addr_q == laser_safety_pkg::ADDR_INT_MASK;
  assign rdStat = doRead && addr_q == laser_safety_pkg::ADDR_INT_STAT;
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] config_q;
  logic [7:0] pwrLo_q;
  logic [7:0] pwrHi_q;
  logic [15:0] frameLen_q;
  logic [15:0] lightLen_q;
  logic [2:0] intMask_q;
  logic faultClr;
  assign faultClr = wrCfg & hwdata[laser_safety_pkg::FAULT_CLEAR_BIT];
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      config_q <= laser_safety_pkg::CONFIG_RST;
    end else if (wrCfg) begin
      config_q <= {31'h0000_0000, hwdata[laser_safety_pkg::MODE_BIT]};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pwrLo_q <= laser_safety_pkg::PWR_LO_RST;
    end else if (wrLo) begin
      pwrLo_q <= hwdata[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pwrHi_q <= laser_safety_pkg::PWR_HI_RST;
    end else if (wrHi) begin
      pwrHi_q <= hwdata[7:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frameLen_q <= laser_safety_pkg::FRAME_LEN_RST;
    end else if (wrFrame) begin
      frameLen_q <= hwdata[15:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lightLen_q <= laser_safety_pkg::LIGHT_LEN_RST;
    end else if (wrFrame) begin
      lightLen_q <= hwdata[31:16];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      intMask_q <= laser_safety_pkg::INT_MASK_RST;
    end else if (wrMask) begin
      intMask_q <= hwdata[2:0];
    end
  end
  assign emitter_power_cfg_lo = pwrLo_q;
  assign emitter_power_cfg_hi = pwrHi_q;
  // reset value 0 is shutter mode, the long-life default
  logic contMode;
  assign contMode = config_q[laser_safety_pkg::MODE_BIT];
  // ----------------------------------------------------------------
  // frame timing for shutter mode
  // ----------------------------------------------------------------
  logic [15:0] frameCnt_q;
  logic frameWrap;
  logic inLight;
  assign frameWrap = frameCnt_q >= frameLen_q;
  assign inLight = frameCnt_q < lightLen_q;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      frameCnt_q <= 16'h0000;
    end else if (frameWrap || !pdSync_q) begin
      frameCnt_q <= 16'h0000;
    end else begin
      frameCnt_q <= frameCnt_q + 16'h0001;
    end
  end
  // ----------------------------------------------------------------
  // self-test sequencer
  // ----------------------------------------------------------------
  laser_safety_pkg::test_state_t tst_q;
  laser_safety_pkg::test_state_t tst_d;
  logic [7:0] stepCnt_q;
  logic stepDone;
  logic testFail_q;
  logic testFail_d;
  logic testBusy;
  assign stepDone = stepCnt_q == laser_safety_pkg::TEST_STEP_CYC;
  assign testBusy = tst_q != laser_safety_pkg::ST_IDLE;
  assign flt.injectFault = tst_q == laser_safety_pkg::ST_INJECT;
  always_comb begin
    tst_d = tst_q;
    testFail_d = testFail_q;
    case (tst_q)
      laser_safety_pkg::ST_IDLE: begin
        if (wrLo) begin
          tst_d = laser_safety_pkg::ST_GND;
          testFail_d = 1'b0;
        end
      end
      laser_safety_pkg::ST_GND: begin
        if (stepDone) begin
          testFail_d = testFail_q | flt.driveShortGnd;
          tst_d = laser_safety_pkg::ST_SUPPLY;
        end
      end
      laser_safety_pkg::ST_SUPPLY: begin
        if (stepDone) begin
          testFail_d = testFail_q | flt.driveShortSup;
          tst_d = laser_safety_pkg::ST_INJECT;
        end
      end
      laser_safety_pkg::ST_INJECT: begin
        if (stepDone) begin
          // detector must see the injected short, else it is broken
          testFail_d = testFail_q | ~flt.driveShortGnd;
          tst_d = laser_safety_pkg::ST_DONE;
        end
      end
      laser_safety_pkg::ST_DONE: begin
        tst_d = laser_safety_pkg::ST_IDLE;
      end
      default: begin
        tst_d = laser_safety_pkg::ST_IDLE;
      end
    endcase
    // a write mid-test restarts it, so every write gets a whole test
    if (wrLo) begin
      tst_d = laser_safety_pkg::ST_GND;
      testFail_d = 1'b0;
    end
  end
  logic stepClr;
  assign stepClr = tst_d != tst_q || stepDone || wrLo;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tst_q <= laser_safety_pkg::ST_IDLE;
    end else begin
      tst_q <= tst_d;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      testFail_q <= 1'b0;
    end else begin
      testFail_q <= testFail_d;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stepCnt_q <= 8'h00;
    end else if (stepClr) begin
      stepCnt_q <= 8'h00;
    end else begin
      stepCnt_q <= stepCnt_q + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // fault latch and drive control
  // ----------------------------------------------------------------
  logic liveFault;
  logic fault_q;
  logic testEnd;
  assign testEnd = tst_q == laser_safety_pkg::ST_DONE;
  // injected pulse is masked from the live path so a self-test never trips it
  assign liveFault = flt.rbinShort | (flt.driveShortGnd & ~flt.injectFault);
  // a failed self-test latches like a live short
  logic faultSet;
  assign faultSet = liveFault | (testEnd & testFail_q);
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fault_q <= 1'b0;
    end else if (faultSet) begin
      fault_q <= 1'b1;
    end else if (faultClr) begin
      fault_q <= 1'b0;
    end
  end
  logic driveWant;
  logic driveOn;
  assign driveWant = contMode ? 1'b1 : inLight;
  // drive stays off during self-test so the probe sees an idle pin
  assign driveOn = driveWant & pdSync_q & ~fault_q & ~liveFault & ~testBusy;
  logic supplyOff;
  assign supplyOff = fault_q | liveFault;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      driveCurrentEn <= 1'b0;
    end else begin
      driveCurrentEn <= driveOn;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      emitter_supply_enable_n <= 1'b1;
    end else begin
      emitter_supply_enable_n <= supplyOff;
    end
  end
  // ----------------------------------------------------------------
  // interrupts: fault, self-test done, self-test fail
  // ----------------------------------------------------------------
  logic [2:0] intStat_q;
  logic [2:0] intEvt;
  assign intEvt = {testEnd & testFail_q, testEnd, liveFault};
  // an event in the cycle of the clearing read survives it: set wins
  genvar b;
  generate
    for (b = 0; b < 3; b++) begin : g_int
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          intStat_q[b] <= 1'b0;
        end else if (intEvt[b]) begin
          intStat_q[b] <= 1'b1;
        end else if (rdStat) begin
          intStat_q[b] <= 1'b0;
        end
      end
    end
  endgenerate
  assign irq = |(intStat_q & intMask_q);
  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic rdSelCfg;
  logic rdSelLo;
  logic rdSelHi;
  logic rdSelFrame;
  logic rdSelStatus;
  logic rdSelIntStat;
  logic rdSelMask;
  logic [31:0] statusWord;
  logic [31:0] rdMux;
  assign rdSelCfg = addr_q == laser_safety_pkg::ADDR_CONFIG;
  assign rdSelLo = addr_q == laser_safety_pkg::ADDR_PWR_LO;
  assign rdSelHi = addr_q == laser_safety_pkg::ADDR_PWR_HI;
  assign rdSelFrame = addr_q == laser_safety_pkg::ADDR_FRAME;
  assign rdSelStatus = addr_q == laser_safety_pkg::ADDR_STATUS;
  assign rdSelIntStat = addr_q == laser_safety_pkg::ADDR_INT_STAT;
  assign rdSelMask = addr_q == laser_safety_pkg::ADDR_INT_MASK;
  assign statusWord = {27'h000_0000, testFail_q, testBusy, pdSync_q, driveCurrentEn, fault_q};
  // unmapped offsets fall through every select and read as zero
  assign rdMux = ({32{rdSelCfg}} & config_q)
    | ({32{rdSelLo}} & {24'h00_0000, pwrLo_q})
    | ({32{rdSelHi}} & {24'h00_0000, pwrHi_q})
    | ({32{rdSelFrame}} & {lightLen_q, frameLen_q})
    | ({32{rdSelStatus}} & statusWord)
    | ({32{rdSelIntStat}} & {29'h0000_0000, intStat_q})
    | ({32{rdSelMask}} & {29'h0000_0000, intMask_q});
  assign hrdata = rdMux;
endmodule

/* File: verif/laser_safety_assertions.sv */
`timescale 1ns/1ps
module laser_safety_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic power_down_n,
  input wire logic rbinLowRaw,
  input wire logic driveLowRaw,
  input wire logic driveCurrentEn,
  input wire logic emitter_supply_enable_n,
  input wire logic [7:0] emitter_power_cfg_lo
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence s_wr_lo;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == laser_safety_pkg::ADDR_PWR_LO;
  endsequence
  sequence s_pin_short;
    driveLowRaw [*3];
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_pwr_down;
    !power_down_n [*3] |=> !driveCurrentEn;
  endproperty
  a_pwr_down: assert property (p_pwr_down)
    else $error("drive on while powered down");
  property p_rbin_cut;
    rbinLowRaw [*3] |=> emitter_supply_enable_n && !driveCurrentEn;
  endproperty
  a_rbin_cut: assert property (p_rbin_cut)
    else $error("bias short did not cut drive");
  property p_pin_cut;
    s_pin_short |=> emitter_supply_enable_n && !driveCurrentEn;
  endproperty
  a_pin_cut: assert property (p_pin_cut)
    else $error("drive pin short did not cut drive");
  property p_supply_pair;
    emitter_supply_enable_n |-> !driveCurrentEn;
  endproperty
  a_supply_pair: assert property (p_supply_pair)
    else $error("current source on with supply cut");
  property p_release;
    $fell(emitter_supply_enable_n) |-> !$past(rbinLowRaw) && !$past(driveLowRaw);
  endproperty
  a_release: assert property (p_release)
    else $error("supply restored during live short");
  // the short must pass the synchroniser before it acts
  property p_sync;
    $rose(rbinLowRaw) && !emitter_supply_enable_n |=> !emitter_supply_enable_n [*2];
  endproperty
  a_sync: assert property (p_sync)
    else $error("raw comparator used unsynchronised");
  property p_lo_store;
    s_wr_lo ##1 1'b1 |=> emitter_power_cfg_lo == $past(hwdata[7:0]);
  endproperty
  a_lo_store: assert property (p_lo_store)
    else $error("low power config not stored");
  property p_test_off;
    s_wr_lo |=> ##3 !driveCurrentEn [*8];
  endproperty
  a_test_off: assert property (p_test_off)
    else $error("drive on during self-test");
endmodule
bind laser_drive_safety_control laser_safety_assertions chk_i (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsel(hsel),
  .hready(hready),
  .hwdata(hwdata),
  .power_down_n(power_down_n),
  .rbinLowRaw(rbinLowRaw),
  .driveLowRaw(driveLowRaw),
  .driveCurrentEn(driveCurrentEn),
  .emitter_supply_enable_n(emitter_supply_enable_n),
  .emitter_power_cfg_lo(emitter_power_cfg_lo)
);

/* File: verif/emitter_partner.sv */
`timescale 1ns/1ps
module emitter_partner (
  input wire logic emitter_supply_enable_n,
  input wire logic driveCurrentEn,
  input wire logic [2:0] shortSel,
  output logic rbinLowRaw,
  output logic driveLowRaw,
  output logic driveHighRaw,
  output logic lightOn
);
  // comparators are analog: they move off the clock edge
  assign #2 rbinLowRaw = shortSel[0];
  assign #2 driveLowRaw = shortSel[1];
  assign #2 driveHighRaw = shortSel[2];
  // pnp conducts only while its base is pulled low
  assign lightOn = !emitter_supply_enable_n && driveCurrentEn;
endmodule

/* File: verif/laser_drive_safety_control_bench.sv */
`timescale 1ns/1ps
module laser_drive_safety_control_bench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic power_down_n = 1'b1;
  logic [2:0] shortSel = 3'h0;
  logic rdPh = 1'b0;
  logic [31:0] hrdata, rnd, rdHold;
  logic hreadyout, hresp, rbinLow, driveLow, driveHigh, driveEn, supplyN, irq, lightOn;
  logic [7:0] cfgLo, cfgHi;
  logic [31:0] expQ[$];
  int errors = 0;
  int checks_done = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  laser_drive_safety_control uut (.clk_sys(clk_sys), .rst_b(rst_b), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hsel(1'b1), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .power_down_n(power_down_n), .rbinLowRaw(rbinLow), .driveLowRaw(driveLow),
    .driveHighRaw(driveHigh), .driveCurrentEn(driveEn), .emitter_supply_enable_n(supplyN),
    .emitter_power_cfg_lo(cfgLo), .emitter_power_cfg_hi(cfgHi), .irq(irq));
  emitter_partner far (.emitter_supply_enable_n(supplyN), .driveCurrentEn(driveEn),
    .shortSel(shortSel), .rbinLowRaw(rbinLow), .driveLowRaw(driveLow),
    .driveHighRaw(driveHigh), .lightOn(lightOn));
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hrdata may move at the closing edge, so keep what stood just before it
  always @(negedge clk_sys) rdHold <= hrdata;
  always @(posedge clk_sys) begin
    if (rdPh && hreadyout === 1'b1) chk(rdHold, expQ.pop_front());
    if (rdPh && hreadyout === 1'b1) chk(32'(hresp), 32'h0000_0000);
    rdPh <= htrans[1] && !hwrite && hreadyout === 1'b1;
  end
  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rdy;
    int k;
    k = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 64) begin
        errors++;
        give_verdict();
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic count_on(input int c, output int on);
    on = 0;
    repeat (c) begin
      @(posedge clk_sys);
      if (driveEn === 1'b1) on++;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rnd = 32'h0000_cfa8;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    // firmware leaves the mode at shutter out of reset
    rd(laser_safety_pkg::ADDR_CONFIG, laser_safety_pkg::CONFIG_RST);
    rd(laser_safety_pkg::ADDR_FRAME,
      {laser_safety_pkg::LIGHT_LEN_RST, laser_safety_pkg::FRAME_LEN_RST});
    rd(8'h1C, 32'h0000_0000);
    rnd = lfsr(rnd);
    bus(1'b1, laser_safety_pkg::ADDR_PWR_LO, rnd);
    bus(1'b1, laser_safety_pkg::ADDR_PWR_HI, ~rnd);
    @(posedge clk_sys);
    chk({24'h00_0000, cfgLo}, {24'h00_0000, rnd[7:0]});
    chk({24'h00_0000, cfgHi}, {24'h00_0000, ~rnd[7:0]});
    $display("test 1 done");
    bus(1'b1, laser_safety_pkg::ADDR_FRAME, 32'h0004_0009);
    repeat (150) @(posedge clk_sys);
    chk(32'(supplyN), 32'h0000_0000);
    rd(laser_safety_pkg::ADDR_INT_STAT, 32'h0000_0002);
    count_on(100, n);
    chk(n, 32'h0000_0028);
    $display("test 2 done");
    bus(1'b1, laser_safety_pkg::ADDR_CONFIG, 32'h0000_0001);
    repeat (4) @(posedge clk_sys);
    count_on(50, n);
    chk(n, 32'h0000_0032);
    power_down_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk(32'(driveEn), 32'h0000_0000);
    power_down_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(32'(lightOn), 32'h0000_0001);
    $display("test 3 done");
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, laser_safety_pkg::ADDR_INT_MASK, p ? 32'h0000_0000 : 32'h0000_0007);
      shortSel <= 3'(1 << p);
      repeat (5) @(posedge clk_sys);
      chk(32'(supplyN), 32'h0000_0001);
      chk(32'(lightOn), 32'h0000_0000);
      chk(32'(irq), 32'(p == 0));
      // a clear during a live short must not restore the supply
      bus(1'b1, laser_safety_pkg::ADDR_CONFIG, 32'h0000_0003);
      repeat (3) @(posedge clk_sys);
      chk(32'(supplyN), 32'h0000_0001);
      shortSel <= 3'h0;
      repeat (4) @(posedge clk_sys);
      bus(1'b1, laser_safety_pkg::ADDR_CONFIG, 32'h0000_0003);
      rd(laser_safety_pkg::ADDR_INT_STAT, 32'h0000_0001);
      repeat (4) @(posedge clk_sys);
      chk(32'(supplyN), 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
    end
    $display("test 4 done");
    bus(1'b1, laser_safety_pkg::ADDR_INT_MASK, 32'h0000_0004);
    shortSel <= 3'h4;
    rnd = lfsr(rnd);
    bus(1'b1, laser_safety_pkg::ADDR_PWR_LO, rnd);
    repeat (150) @(posedge clk_sys);
    chk(32'(supplyN), 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    rd(laser_safety_pkg::ADDR_STATUS, 32'h0000_0015);
    rd(laser_safety_pkg::ADDR_INT_STAT, 32'h0000_0006);
    shortSel <= 3'h0;
    bus(1'b1, laser_safety_pkg::ADDR_CONFIG, 32'h0000_0002);
    repeat (4) @(posedge clk_sys);
    chk(32'(supplyN), 32'h0000_0000);
    $display("test 5 done");
    give_verdict();
  end
endmodule
